/* File: rtl/sfa_defs.svh */
/*
 * Constants for the self-programming access controller: control/status bit
 * positions, command codes, fixed pointer values, register map, op codes.
 * Assumes it is included by bare name from the controller and the bench.
 */
`ifndef SFA_DEFS_SVH
`define SFA_DEFS_SVH

// ----------------------------------------
// control/status bits of the device
// ----------------------------------------
`define SFA_BIT_EN 0
`define SFA_BIT_LOCK 3
`define SFA_BIT_RE 4
`define SFA_BIT_SIG 5
`define SFA_BIT_BUSY 6
`define SFA_CMD_LOCK_SET 8'h09
`define SFA_CMD_LOCK_RD 8'h09
`define SFA_CMD_SIG_RD 8'h21
`define SFA_CMD_RE 8'h11

// ----------------------------------------
// pointer values and data
// ----------------------------------------
`define SFA_Z_LOCK 16'h0001
`define SFA_Z_FLB 16'h0000
`define SFA_Z_FHB 16'h0003
`define SFA_Z_EFB 16'h0002
`define SFA_R0_TOP 2'h3
`define SFA_LOCK_RST 6'h3f
`define SFA_LOW_RST 8'hff

// ----------------------------------------
// op codes
// ----------------------------------------
`define SFA_OP_LOCK_WR 3'h0
`define SFA_OP_LOCK_RD 3'h1
`define SFA_OP_FLB 3'h2
`define SFA_OP_FHB 3'h3
`define SFA_OP_EFB 3'h4
`define SFA_OP_SIG 3'h5
`define SFA_OP_RE 3'h6

// ----------------------------------------
// software register map
// ----------------------------------------
`define SFA_REG_CMD 4'h0
`define SFA_REG_ARG 4'h4
`define SFA_REG_STAT 4'h8
`define SFA_RESP_OK 2'h0
`define SFA_RESP_ERR 2'h2

`endif

/* File: rtl/sfa_pkg.sv */
/*
 * Types for the self-programming access controller.
 * Assumes sfa_defs.svh is reachable on the include path.
 */
package sfa_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_WAIT_EN,
    ST_WAIT_EE,
    ST_ISSUE,
    ST_CAPTURE,
    ST_POLL
  } sfa_state_t;
endpackage

/* File: rtl/sfa_host.sv */
/*
 * Controller playing the CPU side of the self-programming access logic:
 * software orders lock writes, lock/fuse/signature reads and section
 * re-enable over AXI4-Lite; the controller runs the timed sequence on the
 * device pins. Assumes device pins are synchronous to CLK and that load
 * data is valid the cycle after the load strobe.
 */
// How it works
// - lock-set code then store within four cycles
// - pointer loaded with 0x0001 for lock writes
// - data bits 7 and 6 driven high
// - poll EEPROM busy before control write
// - lock read: pointer 0x0001, load within three
// - pointer 0x0000 returns fuse low byte
// - pointer 0x0003 returns fuse high byte
// - pointer 0x0002 returns extended fuse byte
// - signature select, pointer, load within three
// - wait enable clear, EEPROM clear, then command
// - re-enable section, poll busy until clear
`timescale 1ns/1ps
`include "sfa_defs.svh"

module sfa_host import sfa_pkg::*; (
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // axi4-lite write address and data
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [3:0] S_AXI_AWADDR,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  // axi4-lite write response
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  output logic [1:0] S_AXI_BRESP,
  // axi4-lite read
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  input wire logic [3:0] S_AXI_ARADDR,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  // device control/status register port
  output logic CTRL_WR,
  output logic [7:0] CTRL_WDATA,
  input wire logic [7:0] CTRL_RDATA,
  // device instruction port
  output logic STORE_STB,
  output logic LOAD_STB,
  output logic [15:0] ZPTR,
  output logic [7:0] LOW_DATA,
  input wire logic [7:0] LOAD_DATA,
  // eeprom status
  input wire logic EEPROM_WRITE_BUSY
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [7:0] ctrl_value(input logic [2:0] op);
    logic [7:0] v;
    v = `SFA_CMD_LOCK_RD;
    if (op == `SFA_OP_LOCK_WR) begin
      v = `SFA_CMD_LOCK_SET;
    end else if (op == `SFA_OP_SIG) begin
      v = `SFA_CMD_SIG_RD;
    end else if (op == `SFA_OP_RE) begin
      v = `SFA_CMD_RE;
    end
    return v;
  endfunction

  function automatic logic [15:0] ptr_value(input logic [2:0] op, input logic [15:0] a);
    logic [15:0] v;
    v = a;
    if (op == `SFA_OP_LOCK_WR || op == `SFA_OP_LOCK_RD) begin
      v = `SFA_Z_LOCK;
    end else if (op == `SFA_OP_FLB) begin
      v = `SFA_Z_FLB;
    end else if (op == `SFA_OP_FHB) begin
      v = `SFA_Z_FHB;
    end else if (op == `SFA_OP_EFB) begin
      v = `SFA_Z_EFB;
    end
    return v;
  endfunction

  function automatic logic is_store(input logic [2:0] op);
    return op == `SFA_OP_LOCK_WR || op == `SFA_OP_RE;
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  sfa_state_t state_r, state_nxt;
  logic [2:0] op_r;
  logic [15:0] addr_r;
  logic [5:0] lock_r;
  logic [7:0] result_r;
  logic done_r;
  logic [15:0] zptr_r;
  logic [7:0] low_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  wire wr_fire = S_AXI_AWVALID && S_AXI_WVALID && !bvalid_r;
  wire rd_fire = S_AXI_ARVALID && !rvalid_r;
  wire wr_cmd = wr_fire && S_AXI_AWADDR == `SFA_REG_CMD && S_AXI_WSTRB[0];
  wire wr_arg = wr_fire && S_AXI_AWADDR == `SFA_REG_ARG;
  wire wr_known = S_AXI_AWADDR == `SFA_REG_CMD || S_AXI_AWADDR == `SFA_REG_ARG;
  wire rd_known = S_AXI_ARADDR == `SFA_REG_CMD || S_AXI_ARADDR == `SFA_REG_ARG
    || S_AXI_ARADDR == `SFA_REG_STAT;
  wire busy = state_r != ST_IDLE;
  // a command while busy is dropped; the bus still answers ok
  wire start = wr_cmd && !busy && S_AXI_WDATA[2:0] <= `SFA_OP_RE;
  wire [31:0] rd_word = S_AXI_ARADDR == `SFA_REG_ARG ? {10'h000, lock_r, addr_r}
    : S_AXI_ARADDR == `SFA_REG_STAT ? {16'h0000, result_r, 6'h00, done_r, busy}
    : S_AXI_ARADDR == `SFA_REG_CMD ? {29'h0000000, op_r} : 32'h00000000;

  assign S_AXI_AWREADY = wr_fire;
  assign S_AXI_WREADY = wr_fire;
  assign S_AXI_ARREADY = rd_fire;
  assign S_AXI_BVALID = bvalid_r;
  assign S_AXI_BRESP = bresp_r;
  assign S_AXI_RVALID = rvalid_r;
  assign S_AXI_RDATA = rdata_r;
  assign S_AXI_RRESP = rresp_r;

  // ----------------------------------------
  // sequence decode
  // ----------------------------------------
  wire en_set = CTRL_RDATA[`SFA_BIT_EN];
  wire rww_busy = CTRL_RDATA[`SFA_BIT_BUSY];
  // write only in the very cycle the eeprom is seen idle
  wire ctrl_go = state_r == ST_WAIT_EE && !EEPROM_WRITE_BUSY;
  wire finish = state_r == ST_CAPTURE
    || (state_r == ST_POLL && !en_set && !(op_r == `SFA_OP_RE && rww_busy));

  assign CTRL_WR = ctrl_go;
  assign CTRL_WDATA = ctrl_value(op_r);
  // instruction goes out the first cycle after the write, inside any window
  assign STORE_STB = state_r == ST_ISSUE && is_store(op_r);
  assign LOAD_STB = state_r == ST_ISSUE && !is_store(op_r);
  assign ZPTR = zptr_r;
  assign LOW_DATA = low_r;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: if (start) state_nxt = ST_WAIT_EN;
      ST_WAIT_EN: if (!en_set) state_nxt = ST_WAIT_EE;
      ST_WAIT_EE: if (ctrl_go) state_nxt = ST_ISSUE;
      ST_ISSUE: state_nxt = is_store(op_r) ? ST_POLL : ST_CAPTURE;
      ST_CAPTURE: state_nxt = ST_IDLE;
      ST_POLL: begin
        if (finish) begin
          state_nxt = ST_IDLE;
        end else if (!en_set) begin
          state_nxt = ST_WAIT_EE;
        end
      end
    endcase
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge CLK) begin
    if (RST) begin
      state_r <= ST_IDLE;
      op_r <= `SFA_OP_LOCK_RD;
      addr_r <= 16'h0000;
      lock_r <= `SFA_LOCK_RST;
      zptr_r <= 16'h0000;
      low_r <= `SFA_LOW_RST;
      result_r <= 8'h00;
      done_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (start) begin
        op_r <= S_AXI_WDATA[2:0];
        zptr_r <= ptr_value(S_AXI_WDATA[2:0], addr_r);
        low_r <= {`SFA_R0_TOP, lock_r};
      end
      if (wr_arg && !busy) begin
        addr_r <= S_AXI_WDATA[15:0];
        lock_r <= S_AXI_WDATA[21:16];
      end
      if (state_r == ST_CAPTURE) begin
        result_r <= LOAD_DATA;
      end
      // completion wins over the clearing command write
      if (finish) begin
        done_r <= 1'b1;
      end else if (start) begin
        done_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      bvalid_r <= 1'b0;
      bresp_r <= `SFA_RESP_OK;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= `SFA_RESP_OK;
    end else begin
      if (wr_fire) begin
        bvalid_r <= 1'b1;
        bresp_r <= wr_known ? `SFA_RESP_OK : `SFA_RESP_ERR;
      end else if (S_AXI_BREADY) begin
        bvalid_r <= 1'b0;
      end
      if (rd_fire) begin
        rvalid_r <= 1'b1;
        rdata_r <= rd_word;
        rresp_r <= rd_known ? `SFA_RESP_OK : `SFA_RESP_ERR;
      end else if (S_AXI_RREADY) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_lock_store;
    @(posedge CLK) disable iff (RST)
      CTRL_WR && op_r == `SFA_OP_LOCK_WR |-> CTRL_WDATA == `SFA_CMD_LOCK_SET ##1 STORE_STB;
  endproperty
  a_lock_store: assert property (p_lock_store) else $error("lock write not followed by store");

  property p_lock_ptr;
    @(posedge CLK) disable iff (RST)
      STORE_STB && op_r == `SFA_OP_LOCK_WR |-> ZPTR == `SFA_Z_LOCK;
  endproperty
  a_lock_ptr: assert property (p_lock_ptr) else $error("lock write pointer wrong");

  property p_lock_top;
    @(posedge CLK) disable iff (RST)
      STORE_STB && op_r == `SFA_OP_LOCK_WR |-> LOW_DATA[7:6] == `SFA_R0_TOP;
  endproperty
  a_lock_top: assert property (p_lock_top) else $error("lock data top bits not high");

  property p_ee_idle;
    @(posedge CLK) disable iff (RST)
      CTRL_WR |-> !EEPROM_WRITE_BUSY && $past(state_r) != ST_IDLE;
  endproperty
  a_ee_idle: assert property (p_ee_idle) else $error("control write while eeprom busy");

  property p_lock_read;
    @(posedge CLK) disable iff (RST)
      CTRL_WR && op_r == `SFA_OP_LOCK_RD |=> LOAD_STB && ZPTR == `SFA_Z_LOCK ##1 !LOAD_STB;
  endproperty
  a_lock_read: assert property (p_lock_read) else $error("lock read load missing");

  property p_fuse_ptr;
    @(posedge CLK) disable iff (RST)
      LOAD_STB |-> (op_r != `SFA_OP_FLB || ZPTR == `SFA_Z_FLB)
        && (op_r != `SFA_OP_FHB || ZPTR == `SFA_Z_FHB)
        && (op_r != `SFA_OP_EFB || ZPTR == `SFA_Z_EFB);
  endproperty
  a_fuse_ptr: assert property (p_fuse_ptr) else $error("fuse read pointer wrong");

  property p_sig_read;
    @(posedge CLK) disable iff (RST)
      CTRL_WR && op_r == `SFA_OP_SIG |-> CTRL_WDATA[`SFA_BIT_SIG] && CTRL_WDATA[`SFA_BIT_EN]
        ##1 LOAD_STB ##2 (result_r == $past(LOAD_DATA));
  endproperty
  a_sig_read: assert property (p_sig_read) else $error("signature read sequence wrong");

  property p_en_clear;
    @(posedge CLK) disable iff (RST)
      $past(state_r) == ST_WAIT_EN && state_r == ST_WAIT_EE |-> !$past(en_set);
  endproperty
  a_en_clear: assert property (p_en_clear) else $error("command before enable cleared");

  property p_rww_done;
    @(posedge CLK) disable iff (RST)
      $rose(done_r) && op_r == `SFA_OP_RE |-> !$past(rww_busy);
  endproperty
  a_rww_done: assert property (p_rww_done) else $error("re-enable done while section busy");

  property p_fuse_cmd;
    @(posedge CLK) disable iff (RST)
      CTRL_WR && (op_r == `SFA_OP_FLB || op_r == `SFA_OP_FHB || op_r == `SFA_OP_EFB)
        |-> CTRL_WDATA == `SFA_CMD_LOCK_RD ##1 LOAD_STB;
  endproperty
  a_fuse_cmd: assert property (p_fuse_cmd) else $error("fuse read sequence wrong");

  property p_re_cmd;
    @(posedge CLK) disable iff (RST)
      CTRL_WR && op_r == `SFA_OP_RE |-> CTRL_WDATA == `SFA_CMD_RE ##1 STORE_STB;
  endproperty
  a_re_cmd: assert property (p_re_cmd) else $error("re-enable sequence wrong");

  // an instruction outside the window would be an ordinary access
  property p_stb_window;
    @(posedge CLK) disable iff (RST)
      STORE_STB || LOAD_STB |-> $past(CTRL_WR);
  endproperty
  a_stb_window: assert property (p_stb_window) else $error("instruction outside window");

  property p_sig_ptr;
    @(posedge CLK) disable iff (RST)
      LOAD_STB && op_r == `SFA_OP_SIG |-> ZPTR == addr_r;
  endproperty
  a_sig_ptr: assert property (p_sig_ptr) else $error("signature pointer wrong");

  property p_one_wr;
    @(posedge CLK) disable iff (RST)
      CTRL_WR |=> !CTRL_WR;
  endproperty
  a_one_wr: assert property (p_one_wr) else $error("control register written twice");

  c_lock_wr: cover property (@(posedge CLK) disable iff (RST)
    CTRL_WR && op_r == `SFA_OP_LOCK_WR ##1 STORE_STB);
  c_fuse_rd: cover property (@(posedge CLK) disable iff (RST)
    LOAD_STB && op_r == `SFA_OP_FHB);
  c_rww_retry: cover property (@(posedge CLK) disable iff (RST)
    state_r == ST_POLL && op_r == `SFA_OP_RE ##1 state_r == ST_WAIT_EE);
  c_ee_wait: cover property (@(posedge CLK) disable iff (RST)
    state_r == ST_WAIT_EE && EEPROM_WRITE_BUSY);

endmodule

/* File: verification/sfa_dev.sv */
/*
 * Behavioural model of the device behind the controller: control/status
 * register, timed windows, lock store, fuse and signature bytes.
 * Assumes controller pins change right after rising clk edges.
 */
`timescale 1ns/1ps
module sfa_dev #(
  parameter logic [7:0] FL = 8'h62,
  parameter logic [7:0] FH = 8'hdf,
  parameter logic [7:0] EF = 8'hf9,
  // identity bytes: values arbitrary
  parameter logic [7:0] S1 = 8'h5a,
  parameter logic [7:0] S2 = 8'ha5,
  parameter logic [7:0] S3 = 8'h3c,
  parameter logic [7:0] CAL = 8'h77
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control register
  input wire logic ctrl_wr,
  input wire logic [7:0] ctrl_wdata,
  output logic [7:0] ctrl_rdata,
  // instructions
  input wire logic store_stb,
  input wire logic load_stb,
  input wire logic [15:0] zptr,
  input wire logic [7:0] low_data,
  output logic [7:0] load_data,
  // eeprom
  input wire logic ee_busy
);
  // --------------------
  // state
  // --------------------
  logic [7:0] cr_r = 8'h40;
  logic [7:0] lk_r = 8'hff;
  logic [2:0] win_r = 3'h0;
  logic [4:0] wt_r = 5'h0;
  wire ok = cr_r[0] && win_r > 3'h1;
  wire [7:0] fz = zptr == 16'h1 ? lk_r : zptr == 16'h0 ? FL :
    zptr == 16'h3 ? FH : zptr == 16'h2 ? EF : 8'hff;
  wire [7:0] sg = zptr == 16'h0 ? S1 : zptr == 16'h1 ? CAL :
    zptr == 16'h2 ? S2 : zptr == 16'h4 ? S3 : 8'hff;
  assign ctrl_rdata = cr_r;
  // lock store keeps its value over reset, a write in flight finishes
  always @(posedge clk) begin
    load_data <= ~zptr[7:0];
    if (win_r != 3'h0) win_r <= win_r - 3'h1;
    if (win_r == 3'h1 && wt_r == 5'h0) cr_r[5:0] <= 6'h0;
    if (wt_r != 5'h0) wt_r <= wt_r - 5'h1;
    if (wt_r == 5'h1) cr_r[5:0] <= 6'h0;
    if (ctrl_wr && !ee_busy) begin
      cr_r[5:0] <= ctrl_wdata[5:0];
      win_r <= 3'h4;
    end
    if (store_stb && win_r != 3'h0 && cr_r[0]) begin
      win_r <= 3'h0;
      wt_r <= 5'h14;
      if (cr_r[3]) lk_r <= lk_r & {2'h3, low_data[5:0]};
      if (cr_r[4]) cr_r[6] <= 1'b0;
    end
    if (load_stb && ok && (cr_r[3] || cr_r[5])) begin
      load_data <= cr_r[3] ? fz : sg;
      cr_r[5:0] <= 6'h0;
      win_r <= 3'h0;
    end
    if (rst) begin
      cr_r <= 8'h40;
      win_r <= 3'h0;
      wt_r <= 5'h0;
    end
  end
endmodule

/* File: verification/tb_sfa_host.sv */
/*
 * Self-checking bench: AXI4-Lite orders to the controller, device model
 * on the far side. Assumes sfa_defs.svh on the include path.
 */
`timescale 1ns/1ps
`include "sfa_defs.svh"
module tb_sfa_host;
  localparam logic [7:0] FL = 8'h62, FH = 8'hdf, EF = 8'hf9;
  localparam logic [7:0] S1 = 8'h5a, S2 = 8'ha5, S3 = 8'h3c, CAL = 8'h77;
  logic clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, br = 1'b0;
  logic arv = 1'b0, rr = 1'b0, ee = 1'b0;
  logic [3:0] aw = 4'h0, ar = 4'h0;
  logic [31:0] wd = 32'h0, d;
  wire awr, wrd, bv, arr, rv, cwr, ss, ls;
  wire [1:0] bresp, rresp;
  wire [31:0] rd;
  wire [7:0] cwd, crd, lowd, ld;
  wire [15:0] z;
  int fails = 0, num_checks = 0, cyc = 0, nwr = 0, k;
  logic [15:0] zs;
  logic [7:0] lsd, cw, res;
  logic [1:0] r;
  logic [15:0] sp [5] = '{16'h0, 16'h1, 16'h2, 16'h4, 16'h6};
  logic [7:0] se [5] = '{S1, CAL, S2, S3, 8'hff};
  always #10 clk = ~clk;
  sfa_host u_dut (.CLK(clk), .RST(rst), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
    .S_AXI_AWADDR(aw), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrd), .S_AXI_WDATA(wd),
    .S_AXI_WSTRB(4'hf), .S_AXI_BVALID(bv), .S_AXI_BREADY(br), .S_AXI_BRESP(bresp),
    .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_ARADDR(ar), .S_AXI_RVALID(rv),
    .S_AXI_RREADY(rr), .S_AXI_RDATA(rd), .S_AXI_RRESP(rresp), .CTRL_WR(cwr),
    .CTRL_WDATA(cwd), .CTRL_RDATA(crd), .STORE_STB(ss), .LOAD_STB(ls), .ZPTR(z),
    .LOW_DATA(lowd), .LOAD_DATA(ld), .EEPROM_WRITE_BUSY(ee));
  sfa_dev #(.FL(FL), .FH(FH), .EF(EF), .S1(S1), .S2(S2), .S3(S3), .CAL(CAL)) u_dev (
    .clk(clk), .rst(rst), .ctrl_wr(cwr), .ctrl_wdata(cwd), .ctrl_rdata(crd),
    .store_stb(ss), .load_stb(ls), .zptr(z), .low_data(lowd), .load_data(ld),
    .ee_busy(ee));
  // --------------------
  // tasks
  // --------------------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  // ready is sampled at the negedge before the edge that takes the item
  task automatic axw(input logic [3:0] a, input logic [31:0] v, output logic [1:0] e);
    logic ok;
    @(posedge clk);
    awv <= 1'b1;
    wv <= 1'b1;
    aw <= a;
    wd <= v;
    br <= 1'b1;
    do begin @(negedge clk); ok = awr; @(posedge clk); end while (!ok);
    awv <= 1'b0;
    wv <= 1'b0;
    do begin @(negedge clk); ok = bv; e = bresp; @(posedge clk); end while (!ok);
    br <= 1'b0;
  endtask
  task automatic axr(input logic [3:0] a, output logic [31:0] v, output logic [1:0] e);
    logic ok;
    @(posedge clk);
    arv <= 1'b1;
    ar <= a;
    rr <= 1'b1;
    do begin @(negedge clk); ok = arr; @(posedge clk); end while (!ok);
    arv <= 1'b0;
    do begin @(negedge clk); ok = rv; v = rd; e = rresp; @(posedge clk); end while (!ok);
    rr <= 1'b0;
  endtask
  task automatic start(input logic [2:0] c, input logic [31:0] arg);
    axw(`SFA_REG_ARG, arg, r);
    axw(`SFA_REG_CMD, {29'h0, c}, r);
  endtask
  task automatic fin(output logic [7:0] v);
    d = 32'h0;
    while (d[1] !== 1'b1) axr(`SFA_REG_STAT, d, r);
    v = d[15:8];
  endtask
  task automatic op(input logic [2:0] c, input logic [31:0] arg, output logic [7:0] v);
    start(c, arg);
    fin(v);
  endtask
  task end_of_test;
    if (fails == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cwr) nwr <= nwr + 1;
    if (cwr) cw <= cwd;
    if (ss) zs <= z;
    if (ss) lsd <= lowd;
    if (cyc == 20000) begin
      fails++;
      end_of_test;
    end
  end
  // --------------------
  // sequence
  // --------------------
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    axr(`SFA_REG_STAT, d, r);
    chk("stat reset", 32'h0, d);
    axw(4'hc, 32'h0, r);
    chk("unmapped bresp", `SFA_RESP_ERR, r);
    axr(4'hc, d, r);
    chk("unmapped rresp", `SFA_RESP_ERR, r);
    op(`SFA_OP_FLB, 32'h0, res);
    chk("fuse low", FL, res);
    op(`SFA_OP_FHB, 32'h0, res);
    chk("fuse high", FH, res);
    op(`SFA_OP_EFB, 32'h0, res);
    chk("fuse ext", EF, res);
    op(`SFA_OP_LOCK_RD, 32'h0, res);
    chk("lock fresh", 8'hff, res);
    op(`SFA_OP_LOCK_WR, {10'h0, 6'h2a, 16'h0}, res);
    chk("lock cmd", 8'h09, cw);
    chk("lock ptr", 16'h0001, zs);
    chk("lock data", 8'hea, lsd);
    op(`SFA_OP_LOCK_RD, 32'h0, res);
    chk("lock after", 8'hea, res);
    axr(`SFA_REG_CMD, d, r);
    chk("last op", 32'h1, {29'h0, d[2:0]});
    for (int i = 0; i < 5; i++) begin
      op(`SFA_OP_SIG, {16'h0, sp[i]}, res);
      chk("signature", se[i], res);
    end
    chk("sig cmd", 8'h21, cw);
    chk("busy before", 1'b1, crd[6]);
    op(`SFA_OP_RE, 32'h0, res);
    chk("busy after", 1'b0, crd[6]);
    chk("re cmd", 8'h11, cw);
    @(posedge clk);
    ee <= 1'b1;
    start(`SFA_OP_FHB, 32'h0);
    k = nwr;
    repeat (10) @(posedge clk);
    chk("ctrl held", k, nwr);
    axr(`SFA_REG_STAT, d, r);
    chk("stat busy", 1'b1, d[0]);
    ee <= 1'b0;
    fin(res);
    chk("fuse high late", FH, res);
    end_of_test;
  end
endmodule
